// ---- dlb_pkg.sv ----
// constants for the decimal-adjust, loop-branch and byte-decrement executor
// assumes a single 16-bit core with an 8-bit condition flag byte
package dlb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // opcode bytes
  localparam logic [7:0] OP_PAGE2 = 8'h18;
  localparam logic [7:0] OP_BCD_ADJ = 8'h07;
  localparam logic [7:0] OP_LOOP = 8'h04;
  localparam logic [7:0] OP_DEC_EXT = 8'h73;
  localparam logic [7:0] OP_DEC_IDX = 8'h63;
  localparam logic [7:0] OP_DEC_A = 8'h43;

  ////////////////////////////////////////////////////////////////////////////
  // loop postbyte fields
  localparam int LPB_OP_HI = 7;
  localparam int LPB_OP_LO = 6;
  localparam int LPB_NE_BIT = 5;
  localparam int LPB_SIGN_BIT = 4;
  localparam logic [1:0] LOOP_DEC = 2'h0;
  localparam logic [1:0] LOOP_TEST = 2'h1;
  localparam logic [1:0] LOOP_INC = 2'h2;
  localparam logic [2:0] SEL_A = 3'h0;
  localparam logic [2:0] SEL_B = 3'h1;
  localparam logic [2:0] SEL_D = 3'h4;
  localparam logic [2:0] SEL_X = 3'h5;
  localparam logic [2:0] SEL_Y = 3'h6;
  localparam logic [2:0] SEL_SP = 3'h7;
  localparam logic [15:0] LOOP_LEN = 16'h0003;

  ////////////////////////////////////////////////////////////////////////////
  // condition flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int FLG_H = 5;

  ////////////////////////////////////////////////////////////////////////////
  // decimal adjust corrections and reset values
  localparam logic [7:0] BCD_LO_FIX = 8'h06;
  localparam logic [7:0] BCD_HI_FIX = 8'h60;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [7:0] BYTE_OVF = 8'h80;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

endpackage : dlb_pkg

// ---- dlb_loop_if.sv ----
// signals between the executor core and its loop counter unit
// assumes both ends sit on the same clock; the unit is purely combinational
`timescale 1ns/100ps
`default_nettype none
interface dlb_loop_if;
  logic [7:0] loop_postbyte;
  logic [7:0] offset;
  logic [15:0] pc_in;
  logic [15:0] cnt_in;
  logic byte_cnt;
  logic [15:0] cnt_out;
  logic take;
  logic [15:0] target;
  logic bad_op;
  modport unit (input loop_postbyte, offset, pc_in, cnt_in, byte_cnt,
                output cnt_out, take, target, bad_op);
  modport core (output loop_postbyte, offset, pc_in, cnt_in, byte_cnt,
                input cnt_out, take, target, bad_op);
endinterface : dlb_loop_if
`default_nettype wire

// ---- dlb_loop_unit.sv ----
// counter modify, zero decision and signed_branch_offset target of a loop primitive
// assumes the core has already picked the counter register
`timescale 1ns/100ps
`default_nettype none
module dlb_loop_unit
  import dlb_pkg::*;
(
  dlb_loop_if.unit lp
);

  logic [15:0] raw;
  logic [15:0] rel;
  logic zero;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    lp.bad_op = 1'b0;
    case (lp.loop_postbyte[LPB_OP_HI:LPB_OP_LO])
      LOOP_DEC: raw = lp.cnt_in - 16'h0001; // RULE_03
      LOOP_INC: raw = lp.cnt_in + 16'h0001; // RULE_09
      LOOP_TEST: raw = lp.cnt_in; // RULE_09
      default:
      begin
        raw = lp.cnt_in;
        lp.bad_op = 1'b1;
      end
    endcase
  end

  // byte counters wrap in 8 bits, so only the low byte decides
  assign lp.cnt_out = lp.byte_cnt ? {8'h00, raw[7:0]} : raw;
  assign zero = lp.byte_cnt ? (raw[7:0] == 8'h00) : (raw == 16'h0000);
  assign lp.take = !lp.bad_op && (lp.loop_postbyte[LPB_NE_BIT] ? !zero : zero); // RULE_04
  // bit 4 is the sign of the 9-bit offset, bit 3 unused
  assign rel = {{7{lp.loop_postbyte[LPB_SIGN_BIT]}}, lp.loop_postbyte[LPB_SIGN_BIT],
                lp.offset}; // RULE_07
  assign lp.target = lp.pc_in + LOOP_LEN + rel; // RULE_05

endmodule : dlb_loop_unit
`default_nettype wire

// ---- dlb_exec.sv ----
// executor for decimal adjust, loop branches and byte decrements
// assumes the fetch side presents a whole instruction plus register state
// in one cycle; results appear on registered outputs one edge later
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RULE_01 - decimal adjust sets n, z, bcd carry
// RULE_02 - add 00, 06, 60 or 66 correction
// RULE_03 - decrement counter, branch when zero
// RULE_04 - decrement counter, branch when nonzero
// RULE_05 - three bytes, 9-bit offset from next
// RULE_06 - opcode 04, postbyte bits 7:6 pick operation
// RULE_07 - bit5 eq/ne, bit4 sign, bit3 ignored
// RULE_08 - bits 2:0 select counter register
// RULE_09 - increment and test forms otherwise identical
// RULE_10 - loop primitives leave flags unchanged
// RULE_11 - memory decrement, opcodes 73 and 63
// RULE_12 - n from bit7, z on zero
// RULE_13 - byte decrements keep carry
// RULE_14 - v set only when operand was 80
// RULE_15 - accumulator a decrement, opcode 43
module dlb_exec
  import dlb_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [7:0] opcode0,
  input wire logic [7:0] opcode1,
  input wire logic [7:0] opcode2,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] acc_a,
  input wire logic [7:0] acc_b,
  input wire logic [15:0] idx_x,
  input wire logic [15:0] idx_y,
  input wire logic [15:0] stack_pointer_reg,
  input wire logic [7:0] condition_flags,
  input wire logic [7:0] mem_operand,
  output logic done,
  output logic illegal,
  output logic branch_taken,
  output logic [15:0] pc_out,
  output logic [7:0] acc_a_out,
  output logic [7:0] acc_b_out,
  output logic [15:0] idx_x_out,
  output logic [15:0] idx_y_out,
  output logic [15:0] sp_out,
  output logic [7:0] flags_out,
  output logic mem_wr,
  output logic [7:0] mem_wr_data
);

  if (ADDR_W != 16)
  begin : g_bad_width
    $error("dlb_exec serves only a 16-bit address");
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  dlb_loop_if lp ();
  dlb_loop_unit u_loop (.lp(lp));

  logic is_bcd_adj;
  logic is_loop;
  logic is_dec_mem;
  logic is_dec_a;
  logic [2:0] sel;

  assign is_bcd_adj = (opcode0 == OP_PAGE2) && (opcode1 == OP_BCD_ADJ); // RULE_01
  assign is_loop = (opcode0 == OP_LOOP); // RULE_06
  assign is_dec_mem = (opcode0 == OP_DEC_EXT) || (opcode0 == OP_DEC_IDX); // RULE_11
  assign is_dec_a = (opcode0 == OP_DEC_A); // RULE_15
  assign sel = opcode1[2:0];

  function automatic logic sel_ok(input logic [2:0] s);
    sel_ok = (s == SEL_A) || (s == SEL_B) || (s == SEL_D) ||
             (s == SEL_X) || (s == SEL_Y) || (s == SEL_SP);
  endfunction : sel_ok

  function automatic logic [15:0] sel_cnt(input logic [2:0] s, input logic [7:0] a,
                                           input logic [7:0] b, input logic [15:0] x,
                                           input logic [15:0] y, input logic [15:0] sp);
    case (s)
      SEL_A: sel_cnt = {8'h00, a};
      SEL_B: sel_cnt = {8'h00, b};
      SEL_D: sel_cnt = {a, b};
      SEL_X: sel_cnt = x;
      SEL_Y: sel_cnt = y;
      SEL_SP: sel_cnt = sp;
      default: sel_cnt = RST_WORD;
    endcase
  endfunction : sel_cnt

  assign lp.loop_postbyte = opcode1;
  assign lp.offset = opcode2;
  assign lp.pc_in = pc_in;
  assign lp.cnt_in = sel_cnt(sel, acc_a, acc_b, idx_x, idx_y, stack_pointer_reg); // RULE_08
  assign lp.byte_cnt = (sel == SEL_A) || (sel == SEL_B);

  logic loop_ok;
  assign loop_ok = is_loop && sel_ok(sel) && !lp.bad_op; // RULE_08

  ////////////////////////////////////////////////////////////////////////////
  // decimal adjust
  logic lo_fix;
  logic hi_fix;
  logic [7:0] bcd_res;
  assign lo_fix = condition_flags[FLG_H] || (acc_a[3:0] > BCD_MAX); // RULE_02
  assign hi_fix = condition_flags[FLG_C] || (acc_a[7:4] > BCD_MAX) ||
                  ((acc_a[7:4] == BCD_MAX) && (acc_a[3:0] > BCD_MAX)); // RULE_02
  assign bcd_res = acc_a + (lo_fix ? BCD_LO_FIX : RST_BYTE) + (hi_fix ? BCD_HI_FIX : RST_BYTE);

  ////////////////////////////////////////////////////////////////////////////
  // byte decrement
  logic [7:0] dec_src;
  logic [7:0] dec_res;
  assign dec_src = is_dec_a ? acc_a : mem_operand;
  assign dec_res = dec_src - 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // next flags; v of decimal adjust is left as it was (undefined)
  logic [7:0] next_flags;
  always_comb
  begin
    next_flags = condition_flags; // RULE_10
    if (is_bcd_adj)
    begin
      next_flags[FLG_N] = bcd_res[7]; // RULE_01
      next_flags[FLG_Z] = (bcd_res == RST_BYTE); // RULE_01
      next_flags[FLG_C] = hi_fix; // RULE_01
    end
    else if (is_dec_a || is_dec_mem)
    begin
      next_flags[FLG_N] = dec_res[7]; // RULE_12
      next_flags[FLG_Z] = (dec_res == RST_BYTE); // RULE_12
      next_flags[FLG_V] = (dec_src == BYTE_OVF); // RULE_14
    end
  end

  logic known;
  assign known = is_bcd_adj || loop_ok || is_dec_mem || is_dec_a;

  ////////////////////////////////////////////////////////////////////////////
  // register write-back; carry is never touched by decrements
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      acc_a_out <= RST_BYTE;
      acc_b_out <= RST_BYTE;
      idx_x_out <= RST_WORD;
      idx_y_out <= RST_WORD;
      sp_out <= RST_WORD;
      flags_out <= RST_BYTE;
    end
    else if (instr_valid)
    begin
      acc_a_out <= acc_a;
      acc_b_out <= acc_b;
      idx_x_out <= idx_x;
      idx_y_out <= idx_y;
      sp_out <= stack_pointer_reg;
      flags_out <= known ? next_flags : condition_flags; // RULE_13
      if (is_bcd_adj)
        acc_a_out <= bcd_res; // RULE_02
      else if (is_dec_a)
        acc_a_out <= dec_res; // RULE_15
      else if (loop_ok)
      begin
        case (sel)
          SEL_A: acc_a_out <= lp.cnt_out[7:0]; // RULE_09
          SEL_B: acc_b_out <= lp.cnt_out[7:0];
          SEL_D:
          begin
            acc_a_out <= lp.cnt_out[15:8];
            acc_b_out <= lp.cnt_out[7:0];
          end
          SEL_X: idx_x_out <= lp.cnt_out;
          SEL_Y: idx_y_out <= lp.cnt_out;
          default: sp_out <= lp.cnt_out;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter and branch
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pc_out <= RST_WORD;
      branch_taken <= 1'b0;
    end
    else
    begin
      branch_taken <= instr_valid && loop_ok && lp.take; // RULE_03
      if (instr_valid)
        pc_out <= (loop_ok && lp.take) ? lp.target : pc_in + LOOP_LEN; // RULE_05
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory write-back and status pulses
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      mem_wr <= 1'b0;
      mem_wr_data <= RST_BYTE;
      done <= 1'b0;
      illegal <= 1'b0;
    end
    else
    begin
      mem_wr <= instr_valid && is_dec_mem; // RULE_11
      if (instr_valid && is_dec_mem)
        mem_wr_data <= dec_res; // RULE_11
      done <= instr_valid && known;
      illegal <= instr_valid && !known; // RULE_08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_BCD_NZ: assert property (instr_valid && is_bcd_adj |=> // RULE_01
    flags_out[FLG_N] == acc_a_out[7] && flags_out[FLG_Z] == (acc_a_out == 8'h00))
    else $error("decimal adjust n or z wrong");
  AST_BCD_CORR: assert property (instr_valid && is_bcd_adj |=> // RULE_02
    (acc_a_out - $past(acc_a)) inside {8'h00, 8'h06, 8'h60, 8'h66} &&
    flags_out[FLG_C] == ((acc_a_out - $past(acc_a)) >= 8'h60))
    else $error("decimal adjust correction wrong");
  AST_LOOP_EQ: assert property (instr_valid && loop_ok && !opcode1[LPB_NE_BIT] |=> // RULE_03
    branch_taken == ($past(lp.cnt_out) == 16'h0000))
    else $error("branch on zero decision wrong");
  AST_LOOP_NE: assert property (instr_valid && loop_ok && opcode1[LPB_NE_BIT] |=> // RULE_04
    branch_taken == ($past(lp.cnt_out) != 16'h0000))
    else $error("branch on nonzero decision wrong");
  AST_LOOP_PC: assert property (instr_valid && loop_ok && lp.take |=> // RULE_05
    pc_out == $past(pc_in) + 16'h0003 + {{7{$past(opcode1[4])}}, $past(opcode1[4]),
    $past(opcode2)})
    else $error("branch target wrong");
  AST_LOOP_FLAGS: assert property (instr_valid && is_loop |=> // RULE_10
    flags_out == $past(condition_flags))
    else $error("loop changed flags");
  AST_BAD_SEL: assert property (instr_valid && is_loop && !sel_ok(sel) |=> // RULE_08
    illegal && !branch_taken)
    else $error("unassigned counter not refused");
  AST_DEC_CARRY: assert property (instr_valid && (is_dec_a || is_dec_mem) |=> // RULE_13
    flags_out[FLG_C] == $past(condition_flags[FLG_C]))
    else $error("decrement changed carry");
  AST_DEC_V: assert property (instr_valid && (is_dec_a || is_dec_mem) |=> // RULE_14
    flags_out[FLG_V] == (($past(is_dec_a) ? $past(acc_a) : $past(mem_operand)) == 8'h80))
    else $error("decrement overflow wrong");
  AST_DEC_A: assert property (instr_valid && is_dec_a |=> // RULE_15
    acc_a_out == $past(acc_a) - 8'h01 && flags_out[FLG_N] == acc_a_out[7] &&
    flags_out[FLG_Z] == (acc_a_out == 8'h00))
    else $error("accumulator decrement wrong");
  AST_MEM_DEC: assert property (instr_valid && is_dec_mem |=> // RULE_11
    mem_wr && mem_wr_data == $past(mem_operand) - 8'h01 ##1 !mem_wr || $past(instr_valid))
    else $error("memory decrement write wrong");
  AST_DEC_NZ: assert property (instr_valid && is_dec_mem |=> // RULE_12
    flags_out[FLG_N] == mem_wr_data[7] && flags_out[FLG_Z] == (mem_wr_data == 8'h00))
    else $error("memory decrement n or z wrong");
  AST_LOOP_TEST: assert property (instr_valid && loop_ok && sel == SEL_X && // RULE_09
    opcode1[LPB_OP_HI:LPB_OP_LO] == LOOP_TEST |=> idx_x_out == $past(idx_x))
    else $error("test form changed its counter");

endmodule : dlb_exec
`default_nettype wire

// ---- dlb_exec_bench.sv ----
// self-checking bench for the dlb_exec executor
// assumes one answer edge after each taken instruction, inputs driven at negedge
`timescale 1ns/100ps
`default_nettype none
module dlb_exec_bench;
  import dlb_pkg::*;
  typedef struct packed {
    logic ill;
    logic tk;
    logic [15:0] pc;
    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] sp;
    logic [7:0] f;
    logic wr;
    logic [7:0] wd;
  } dlb_exp_t;
  logic mclk, rst_n, instr_valid;
  logic [7:0] opcode0, opcode1, opcode2, acc_a, acc_b, condition_flags, mem_operand;
  logic [15:0] pc_in, idx_x, idx_y, stack_pointer_reg;
  wire done, illegal, branch_taken, mem_wr;
  wire [7:0] acc_a_out, acc_b_out, flags_out, mem_wr_data;
  wire [15:0] pc_out, idx_x_out, idx_y_out, sp_out;
  logic [31:0] seed = 32'h8d6f5323;
  logic [31:0] r;
  logic [7:0] last_wd, o0, o1;
  logic [7:0] dv [5] = '{8'h80, 8'h00, 8'h01, 8'h81, 8'h7f};
  logic [7:0] opt [8] = '{8'h43, 8'h73, 8'h63, 8'h04, 8'h04, 8'h18, 8'h18, 8'h00};
  int n_errors, n_tests, i;
  dlb_exp_t expq[$];
  dlb_exp_t ex;

  dlb_exec u_dut (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .opcode0(opcode0),
    .opcode1(opcode1), .opcode2(opcode2), .pc_in(pc_in), .acc_a(acc_a), .acc_b(acc_b),
    .idx_x(idx_x), .idx_y(idx_y), .stack_pointer_reg(stack_pointer_reg),
    .condition_flags(condition_flags), .mem_operand(mem_operand), .done(done),
    .illegal(illegal), .branch_taken(branch_taken), .pc_out(pc_out), .acc_a_out(acc_a_out),
    .acc_b_out(acc_b_out), .idx_x_out(idx_x_out), .idx_y_out(idx_y_out), .sp_out(sp_out),
    .flags_out(flags_out), .mem_wr(mem_wr), .mem_wr_data(mem_wr_data));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // biased toward counts that hit zero after one step
  function automatic logic [15:0] edge16();
    logic [31:0] t;
    t = rnd();
    case (t[17:16])
      2'h0: return 16'h0001;
      2'h1: return 16'hffff;
      2'h2: return 16'h00ff;
      default: return t[15:0];
    endcase
  endfunction : edge16

  function automatic logic [7:0] e8();
    logic [15:0] t;
    t = edge16();
    return t[7:0];
  endfunction : e8

  function automatic dlb_exp_t model();
    dlb_exp_t e;
    logic [15:0] cnt;
    logic [15:0] nc;
    logic [7:0] res;
    logic [7:0] fix;
    logic z;
    e = '{1'b0, 1'b0, pc_in + LOOP_LEN, acc_a, acc_b, idx_x, idx_y, stack_pointer_reg,
          condition_flags, 1'b0, last_wd};
    if (opcode0 == OP_DEC_A || opcode0 == OP_DEC_EXT || opcode0 == OP_DEC_IDX)
    begin
      res = ((opcode0 == OP_DEC_A) ? acc_a : mem_operand) - 8'h01;
      e.f[FLG_N] = res[7];
      e.f[FLG_Z] = (res == 8'h00);
      e.f[FLG_V] = (res == 8'h7f);
      if (opcode0 == OP_DEC_A)
        e.a = res;
      else
        {e.wr, e.wd} = {1'b1, res};
    end
    else if (opcode0 == OP_PAGE2 && opcode1 == OP_BCD_ADJ)
    begin
      fix = 8'h00;
      if (condition_flags[FLG_H] || acc_a[3:0] > 4'h9)
        fix[3:0] = 4'h6;
      e.f[FLG_C] = condition_flags[FLG_C] || acc_a > 8'h99;
      if (e.f[FLG_C])
        fix[7:4] = 4'h6;
      res = acc_a + fix;
      e.a = res;
      e.f[FLG_N] = res[7];
      e.f[FLG_Z] = (res == 8'h00);
    end
    else if (opcode0 == OP_LOOP && opcode1[7:6] != 2'h3 && opcode1[2:1] != 2'h1)
    begin
      case (opcode1[2:0])
        3'h0: cnt = {8'h00, acc_a};
        3'h1: cnt = {8'h00, acc_b};
        3'h4: cnt = {acc_a, acc_b};
        3'h5: cnt = idx_x;
        3'h6: cnt = idx_y;
        default: cnt = stack_pointer_reg;
      endcase
      nc = cnt + ((opcode1[7:6] == LOOP_DEC) ? 16'hffff : {15'h0, opcode1[7]});
      if (opcode1[2:1] == 2'h0)
        nc[15:8] = 8'h00;
      z = (nc == 16'h0000);
      e.tk = opcode1[LPB_NE_BIT] ? !z : z;
      if (e.tk)
        e.pc = pc_in + LOOP_LEN + {{8{opcode1[LPB_SIGN_BIT]}}, opcode2};
      case (opcode1[2:0])
        3'h0: e.a = nc[7:0];
        3'h1: e.b = nc[7:0];
        3'h4: {e.a, e.b} = nc;
        3'h5: e.x = nc;
        3'h6: e.y = nc;
        default: e.sp = nc;
      endcase
    end
    else
      e.ill = 1'b1;
    return e;
  endfunction : model

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic issue(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                       input logic [7:0] a, input logic [7:0] m);
    logic [31:0] t;
    @(negedge mclk);
    t = rnd();
    {instr_valid, opcode0, opcode1, opcode2, acc_a, mem_operand} = {1'b1, b0, b1, b2, a, m};
    {pc_in, condition_flags} = t[23:0];
    acc_b = e8();
    idx_x = edge16();
    idx_y = edge16();
    stack_pointer_reg = edge16();
    expq.push_back(model());
    last_wd = expq[$].wd;
  endtask : issue

  task automatic end_test(input string nm);
    int k;
    @(negedge mclk);
    instr_valid = 1'b0;
    for (k = 0; k < 8 && expq.size() > 0; k++)
      @(negedge mclk);
    if (expq.size() > 0)
    begin
      n_errors++;
      test_done();
    end
    else
      $display("test %s ended", nm);
  endtask : end_test

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk)
  begin
    #1;
    if (done === 1'b1 || illegal === 1'b1)
    begin
      ex = (expq.size() > 0) ? expq.pop_front() : '1;
      check("illegal", illegal, ex.ill);
      check("done", done, !ex.ill);
      check("branch_taken", branch_taken, ex.tk);
      check("pc_out", pc_out, ex.pc);
      check("acc_a_out", acc_a_out, ex.a);
      check("acc_b_out", acc_b_out, ex.b);
      check("idx_x_out", idx_x_out, ex.x);
      check("idx_y_out", idx_y_out, ex.y);
      check("sp_out", sp_out, ex.sp);
      check("flags_out", flags_out, ex.f);
      check("mem_wr", mem_wr, ex.wr);
      check("mem_wr_data", mem_wr_data, ex.wd);
    end
  end

  initial
  begin
    mclk = 1'b0;
    forever
      #25 mclk = ~mclk;
  end

  initial
  begin
    {rst_n, instr_valid, opcode0, opcode1, opcode2, acc_a, acc_b} = '0;
    {condition_flags, mem_operand, pc_in, idx_x, idx_y, stack_pointer_reg} = '0;
    last_wd = RST_BYTE;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    issue(OP_LOOP, 8'h20, 8'h10, 8'h05, 8'h00);
    issue(OP_LOOP, 8'h18, 8'h00, 8'h01, 8'h00);
    issue(OP_LOOP, 8'h28, 8'hff, 8'h02, 8'h00);
    for (i = 0; i < 128; i++)
    begin
      r = rnd();
      issue(OP_LOOP, {i[5:3], r[1:0], i[2:0]}, r[15:8], e8(), 8'h00);
    end
    end_test("loop");
    for (i = 0; i < 15; i++)
      issue(opt[i % 3], 8'h00, 8'h00, dv[i / 3], dv[i / 3]);
    end_test("decrement");
    for (i = 0; i < 64; i++)
    begin
      r = rnd();
      issue(OP_PAGE2, (r[2:0] != 3'h0) ? OP_BCD_ADJ : r[15:8], 8'h00, r[23:16], 8'h00);
    end
    end_test("decimal adjust");
    for (i = 0; i < 400; i++)
    begin
      r = rnd();
      o0 = (r[2:0] == 3'h7) ? r[31:24] : opt[r[2:0]];
      o1 = (o0 == OP_PAGE2 && r[3]) ? OP_BCD_ADJ : r[15:8];
      issue(o0, o1, r[23:16], e8(), e8());
      if (r[4])
        end_test("gap");
    end
    end_test("random");
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    check("reset pc_out", pc_out, RST_WORD);
    check("reset flags_out", flags_out, RST_BYTE);
    check("reset mem_wr_data", mem_wr_data, RST_BYTE);
    rst_n = 1'b1;
    last_wd = RST_BYTE;
    issue(OP_DEC_A, 8'h00, 8'h00, 8'h80, 8'h00);
    end_test("reset");
    test_done();
  end
endmodule : dlb_exec_bench
`default_nettype wire
